// File: core/aeil_pkg.sv
/*
  Package for the alarm and error event latch: register indices, field positions,
  reset values and the bus and event carriers.
  Assumes a single 20 MHz clock domain and a plain strobe register port.
*/
package aeil_pkg;
	localparam logic [15:0] AEIL_STATUS_ADDR   = 16'h0b02;
	localparam logic [15:0] AEIL_ENABLE_ADDR   = 16'h0b03;
	localparam logic [15:0] AEIL_FRAMING_ADDR  = 16'h010b;
	localparam logic [15:0] AEIL_BLOCK_EN_ADDR = 16'h0b00;
	localparam int          AEIL_BIT_VIOL      = 3;
	localparam int          AEIL_BIT_LOSS      = 2;
	localparam int          AEIL_BIT_ONES      = 1;
	localparam int          AEIL_BIT_REMOTE    = 0;
	localparam int          AEIL_BIT_BLK_ALARM = 1;
	localparam int          AEIL_LOSS_STATE    = 7;
	localparam int          AEIL_ONES_STATE    = 6;
	localparam logic [7:0]  AEIL_STATUS_RST    = 8'h00;
	localparam logic [7:0]  AEIL_ENABLE_RST    = 8'h00;
	localparam logic [7:0]  AEIL_BLOCK_EN_RST  = 8'h00;
	localparam logic [2:0]  AEIL_THRESH_RST    = 3'h4;
	localparam logic [7:0]  AEIL_FRAMING_MASK  = 8'h07;
	localparam int          AEIL_CLK_NS        = 50;
	localparam int          AEIL_ONES_TIME_US  = 250;
	localparam int          AEIL_REM_TIME_US   = 375;
	localparam int          AEIL_ONES_CYCLES   = AEIL_ONES_TIME_US * 1000 / AEIL_CLK_NS;
	localparam int          AEIL_REM_CYCLES    = AEIL_REM_TIME_US * 1000 / AEIL_CLK_NS;
	localparam int          AEIL_NUM_EVENTS    = 4;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} aeil_bus_t;

	typedef struct packed {
		logic code_violation;
		logic frame_error;
		logic frame_ok;
		logic all_ones_seen;
		logic zeros_seen;
		logic frame_tick;
		logic nas_frame;
		logic remote_bit;
	} aeil_line_t;
endpackage

// File: core/aeil_flag_bit.sv
/*
  One sticky clear-on-read event flag.
  Assumes the read strobe is one cycle long and the event is a one-cycle pulse.
*/
`timescale 1ns/1ns
module aeil_flag_bit
	import aeil_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic event_pulse,
	input  wire logic read_clear,
	output logic      flag
);
	logic flag_d;
	logic flag_q;

	always_comb
	begin
		flag_d = flag_q;
		if (read_clear)
		begin
			flag_d = 1'b0;
		end
		// A new event beats the read so that it is reported next time.
		if (event_pulse)
		begin
			flag_d = 1'b1; // R11
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flag_q <= 1'b0; // R2
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;
endmodule

// File: core/aeil_latch.sv
/*
  Alarm and error event latch for one E1 receive channel: frame loss, all-ones
  and remote alarm state tracking, sticky clear-on-read event flags, enables
  and the gated interrupt request.
  Assumes line indications are synchronous single-cycle pulses from the
  receive framer and line interface, and a plain strobe register port.
*/
`timescale 1ns/1ns
// Summary of operation
// R1 - Line code violation sets status bit 3 until the status is read.
// R2 - All four flags reset to 0; reading status clears them.
// R3 - Frame loss declare and clear both set status bit 2.
// R4 - Frame loss declared after threshold consecutive bad alignment words, bits 2-0.
// R5 - Every all-ones alarm transition sets status bit 1.
// R6 - Every remote alarm declare or clear sets status bit 0.
// R7 - An event requests an interrupt only when its enable bit is set.
// R8 - All-ones alarm declared after two frames; cleared on zeros in two frames.
// R9 - Remote alarm follows A bit over two consecutive non-alignment frames.
// R10 - Interrupt needs both block alarm enable and source enable.
// R11 - An event coinciding with a status read stays set.
module aeil_latch
	import aeil_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire aeil_bus_t  bus,
	input  wire aeil_line_t line,
	output logic [7:0]      rdata,
	output logic            irq_req,
	output logic            frame_loss_defect,
	output logic            all_ones_alarm,
	output logic            remote_alarm
);
	logic [7:0] rdata_d, rdata_q;
	logic [7:0] enable_d, enable_q;
	logic       block_alarm_enable_d, block_alarm_enable_q;
	logic [2:0] frame_loss_threshold_d, frame_loss_threshold_q;
	logic [2:0] bad_count_d, bad_count_q;
	logic       frame_loss_d, frame_loss_q;
	logic [1:0] ones_frames_d, ones_frames_q;
	logic       ones_zero_d, ones_zero_q;
	logic       all_ones_d, all_ones_q;
	logic [1:0] remote_count_d, remote_count_q;
	logic       remote_d, remote_q;
	logic       irq_d, irq_q;
	logic [AEIL_NUM_EVENTS-1:0] events;
	logic [AEIL_NUM_EVENTS-1:0] flags;
	logic       status_read;

	assign status_read = bus.rd && (bus.addr == AEIL_STATUS_ADDR);

	// Defect state tracking for frame loss, all-ones and remote alarm.
	always_comb
	begin
		bad_count_d    = bad_count_q;
		frame_loss_d   = frame_loss_q;
		ones_frames_d  = ones_frames_q;
		ones_zero_d    = ones_zero_q;
		all_ones_d     = all_ones_q;
		remote_count_d = remote_count_q;
		remote_d       = remote_q;
		if (line.frame_error && !frame_loss_q)
		begin
			if (bad_count_q + 3'h1 >= frame_loss_threshold_q)
			begin
				frame_loss_d = 1'b1; // R4
				bad_count_d  = 3'h0;
			end
			else
				bad_count_d = bad_count_q + 3'h1;
		end
		else if (line.frame_ok)
		begin
			bad_count_d  = 3'h0;
			frame_loss_d = 1'b0;
		end
		if (line.zeros_seen)
			ones_zero_d = 1'b1;
		if (line.frame_tick)
		begin
			// A frame with the zeros threshold crossed breaks the all-ones run.
			if (!all_ones_q)
			begin
				if (line.all_ones_seen && !ones_zero_q && !line.zeros_seen)
				begin
					ones_frames_d = (ones_frames_q == 2'h1) ? 2'h0 : 2'h1;
					all_ones_d    = (ones_frames_q == 2'h1); // R8
				end
				else
					ones_frames_d = 2'h0;
			end
			else
			begin
				if (ones_zero_q || line.zeros_seen)
				begin
					ones_frames_d = (ones_frames_q == 2'h1) ? 2'h0 : 2'h1;
					all_ones_d    = !(ones_frames_q == 2'h1); // R8
				end
				else
					ones_frames_d = 2'h0;
			end
			ones_zero_d = 1'b0;
		end
		if (line.nas_frame)
		begin
			if (line.remote_bit != remote_q)
			begin
				remote_count_d = (remote_count_q == 2'h1) ? 2'h0 : 2'h1;
				if (remote_count_q == 2'h1)
					remote_d = line.remote_bit; // R9
			end
			else
				remote_count_d = 2'h0;
		end
	end

	assign events[AEIL_BIT_VIOL]   = line.code_violation; // R1
	assign events[AEIL_BIT_LOSS]   = frame_loss_d != frame_loss_q; // R3
	assign events[AEIL_BIT_ONES]   = all_ones_d != all_ones_q; // R5
	assign events[AEIL_BIT_REMOTE] = remote_d != remote_q; // R6

	genvar gi;
	generate
		for (gi = 0; gi < AEIL_NUM_EVENTS; gi++)
		begin : g_flag
			aeil_flag_bit u_flag (
				.ref_clk     (ref_clk),
				.rst_n       (rst_n),
				.event_pulse (events[gi]),
				.read_clear  (status_read),
				.flag        (flags[gi])
			);
		end
	endgenerate

	// Register writes, read mux and interrupt gating.
	always_comb
	begin
		enable_d               = enable_q;
		block_alarm_enable_d   = block_alarm_enable_q;
		frame_loss_threshold_d = frame_loss_threshold_q;
		rdata_d                = 8'h00;
		if (bus.wr)
		begin
			case (bus.addr)
				AEIL_ENABLE_ADDR:   enable_d = bus.wdata; // R7
				AEIL_BLOCK_EN_ADDR: block_alarm_enable_d = bus.wdata[AEIL_BIT_BLK_ALARM];
				AEIL_FRAMING_ADDR:  frame_loss_threshold_d = bus.wdata[2:0];
				default: ;
			endcase
		end
		if (bus.rd)
		begin
			case (bus.addr)
				AEIL_STATUS_ADDR:
				begin
					rdata_d = {frame_loss_q, all_ones_q, 2'b00, flags};
				end
				AEIL_ENABLE_ADDR:   rdata_d = enable_q;
				AEIL_BLOCK_EN_ADDR: rdata_d = {6'h00, block_alarm_enable_q, 1'b0};
				AEIL_FRAMING_ADDR:  rdata_d = {5'h00, frame_loss_threshold_q};
				default:            rdata_d = 8'h00;
			endcase
		end
		irq_d = block_alarm_enable_q && |(flags & enable_q[AEIL_NUM_EVENTS-1:0]); // R7 R10
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rdata_q                <= 8'h00;
			enable_q               <= AEIL_ENABLE_RST;
			block_alarm_enable_q   <= AEIL_BLOCK_EN_RST[AEIL_BIT_BLK_ALARM];
			frame_loss_threshold_q <= AEIL_THRESH_RST;
			bad_count_q            <= 3'h0;
			frame_loss_q           <= 1'b0;
			ones_frames_q          <= 2'h0;
			ones_zero_q            <= 1'b0;
			all_ones_q             <= 1'b0;
			remote_count_q         <= 2'h0;
			remote_q               <= 1'b0;
			irq_q                  <= 1'b0;
		end
		else
		begin
			rdata_q                <= rdata_d;
			enable_q               <= enable_d;
			block_alarm_enable_q   <= block_alarm_enable_d;
			frame_loss_threshold_q <= frame_loss_threshold_d;
			bad_count_q            <= bad_count_d;
			frame_loss_q           <= frame_loss_d;
			ones_frames_q          <= ones_frames_d;
			ones_zero_q            <= ones_zero_d;
			all_ones_q             <= all_ones_d;
			remote_count_q         <= remote_count_d;
			remote_q               <= remote_d;
			irq_q                  <= irq_d;
		end
	end

	assign rdata             = rdata_q;
	assign irq_req           = irq_q;
	assign frame_loss_defect = frame_loss_q;
	assign all_ones_alarm    = all_ones_q;
	assign remote_alarm      = remote_q;

	AST_CODE_VIOL_SETS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
		line.code_violation |=> flags[AEIL_BIT_VIOL])
		else $error("line code violation did not set its flag");

	AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
		status_read && !(|events) |=> flags == 4'h0)
		else $error("status read did not clear flags");

	AST_FRAME_LOSS_CHANGE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
		$changed(frame_loss_q) |-> flags[AEIL_BIT_LOSS])
		else $error("frame loss change not flagged");

	AST_FRAME_LOSS_THRESH: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
		$rose(frame_loss_q) |-> $past(line.frame_error))
		else $error("frame loss declared without an errored alignment word");

	AST_ALL_ONES_CHANGE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
		$changed(all_ones_q) |-> flags[AEIL_BIT_ONES])
		else $error("all-ones change not flagged");

	AST_REMOTE_CHANGE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
		$changed(remote_q) |-> flags[AEIL_BIT_REMOTE] && $past(line.nas_frame))
		else $error("remote alarm change not flagged");

	AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
		irq_q |-> $past(block_alarm_enable_q) && $past(|(flags & enable_q[3:0])))
		else $error("interrupt without both enables");

	AST_ALL_ONES_FRAME: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
		$changed(all_ones_q) |-> $past(line.frame_tick))
		else $error("all-ones alarm changed off a frame boundary");

	AST_EVENT_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
		status_read && line.code_violation |=> flags[AEIL_BIT_VIOL])
		else $error("event lost during status read");
endmodule

// File: tb/aeil_latch_bench.sv
/*
  Self-checking bench for the alarm and error event latch: a small integer model
  of the sticky flags and alarm states is compared with most status register reads.
  Assumes the register port and line pulse timing given in the package.
*/
`timescale 1ns/1ns
module aeil_latch_bench
	import aeil_pkg::*;
;
	logic       ref_clk = 1'h0;
	logic       rst_n = 1'h0;
	aeil_bus_t  bus = '0;
	aeil_line_t line = '0;
	logic [7:0] rdata;
	logic       irq_req;
	logic       frame_loss_defect;
	logic       all_ones_alarm;
	logic       remote_alarm;
	int         mismatches = 0;
	int         checks = 0;
	int         seed = 32'he87a;
	int         flg = 0;
	int         loss = 0;
	int         ones = 0;
	int         n;

	always #25 ref_clk = ~ref_clk;

	aeil_latch uut (
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.bus              (bus),
		.line             (line),
		.rdata            (rdata),
		.irq_req          (irq_req),
		.frame_loss_defect(frame_loss_defect),
		.all_ones_alarm   (all_ones_alarm),
		.remote_alarm     (remote_alarm)
	);

	task automatic wrap_up;
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'h1, 1'h0};
		@(posedge ref_clk);
		bus <= '0;
		// One idle edge so the next task never reassigns the bus in this step.
		@(posedge ref_clk);
	endtask

	// The data are sampled at the edge that ends their only valid cycle.
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus <= '{a, 8'h00, 1'h0, 1'h1};
		@(posedge ref_clk);
		bus <= '0;
		line <= '0;
		if (a == AEIL_STATUS_ADDR)
			flg = 0;
		@(posedge ref_clk);
		chk(rdata, e);
	endtask

	// Idle cycles after each pulse let state, flag and request settle.
	task automatic ev(input logic [7:0] m);
		line <= aeil_line_t'(m);
		@(posedge ref_clk);
		line <= '0;
		repeat (4) @(posedge ref_clk);
	endtask

	function automatic logic [7:0] st();
		return {loss[0], ones[0], 2'h0, flg[3:0]};
	endfunction

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(AEIL_STATUS_ADDR, 8'h00);
		rd(AEIL_ENABLE_ADDR, AEIL_ENABLE_RST);
		rd(16'h0bff, 8'h00);
		rd(AEIL_BLOCK_EN_ADDR, AEIL_BLOCK_EN_RST);
		rd(AEIL_FRAMING_ADDR, {5'h00, AEIL_THRESH_RST});
		n = ($random(seed) & 3) + 1;
		repeat (n) ev(8'h80);
		flg = 8;
		rd(AEIL_STATUS_ADDR, st());
		rd(AEIL_STATUS_ADDR, st());
		n = $random(seed) & 8'h0f;
		wr(AEIL_ENABLE_ADDR, n[7:0]);
		rd(AEIL_ENABLE_ADDR, n[7:0]);
		wr(AEIL_FRAMING_ADDR, 8'h02);
		rd(AEIL_FRAMING_ADDR, 8'h02);
		// A good alignment word between errors restarts the consecutive count.
		ev(8'h40);
		ev(8'h20);
		ev(8'h40);
		chk(frame_loss_defect, 8'h00);
		ev(8'h40);
		loss = 1;
		flg = 4;
		chk(frame_loss_defect, 8'h01);
		rd(AEIL_STATUS_ADDR, st());
		ev(8'h20);
		loss = 0;
		flg = 4;
		rd(AEIL_STATUS_ADDR, st());
		repeat (2) ev(8'h14);
		ones = 1;
		flg = 2;
		chk(all_ones_alarm, 8'h01);
		rd(AEIL_STATUS_ADDR, st());
		repeat (2) ev(8'h0c);
		ones = 0;
		flg = 2;
		chk(all_ones_alarm, 8'h00);
		rd(AEIL_STATUS_ADDR, st());
		ev(8'h03);
		ev(8'h02);
		chk(remote_alarm, 8'h00);
		repeat (2) ev(8'h03);
		flg = 1;
		chk(remote_alarm, 8'h01);
		rd(AEIL_STATUS_ADDR, st());
		repeat (2) ev(8'h02);
		flg = 1;
		chk(remote_alarm, 8'h00);
		rd(AEIL_STATUS_ADDR, st());
		wr(AEIL_BLOCK_EN_ADDR, 8'h02);
		rd(AEIL_BLOCK_EN_ADDR, 8'h02);
		wr(AEIL_ENABLE_ADDR, 8'h08);
		ev(8'h80);
		flg = 8;
		chk(irq_req, 8'h01);
		rd(AEIL_STATUS_ADDR, st());
		repeat (2) @(posedge ref_clk);
		chk(irq_req, 8'h00);
		wr(AEIL_ENABLE_ADDR, 8'h04);
		ev(8'h80);
		chk(irq_req, 8'h00);
		rd(AEIL_STATUS_ADDR, 8'h08);
		wr(AEIL_ENABLE_ADDR, 8'h08);
		wr(AEIL_BLOCK_EN_ADDR, 8'h00);
		ev(8'h80);
		chk(irq_req, 8'h00);
		rd(AEIL_STATUS_ADDR, 8'h08);
		// A mid-run reset must drop a pending flag and every written register.
		ev(8'h80);
		rst_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(AEIL_STATUS_ADDR, 8'h00);
		rd(AEIL_ENABLE_ADDR, AEIL_ENABLE_RST);
		rd(AEIL_BLOCK_EN_ADDR, AEIL_BLOCK_EN_RST);
		rd(AEIL_FRAMING_ADDR, {5'h00, AEIL_THRESH_RST});
		chk(irq_req, 8'h00);
		// A violation landing on the read edge must survive into the next read.
		line <= aeil_line_t'(8'h80);
		rd(AEIL_STATUS_ADDR, 8'h00);
		flg = 8;
		rd(AEIL_STATUS_ADDR, st());
		wrap_up;
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		wrap_up;
	end
endmodule
